// *** rtl/flk_pkg.sv ***
// shared constants for the lock, reset and discovery-table command decoder
package flk_pkg;
   localparam logic [7:0] OP_READ_LOCK = 8'h3C;
   localparam logic [7:0] OP_GANG_LOCK = 8'h7E;
   localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
   localparam logic [7:0] OP_RB_ENABLE = 8'h70;
   localparam logic [7:0] OP_RB_DISABLE = 8'h80;
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_READ_TABLE = 8'h5A;

   localparam int SYS_CLK_MHZ = 20;
   localparam int RECOV_PROG_NS = 20000;
   localparam int RECOV_OTHER_NS = 12000;
   localparam int RECOV_PROG_CYC = (RECOV_PROG_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int RECOV_OTHER_CYC = (RECOV_OTHER_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int REC_W = 12;

   localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
   localparam int BLOCK_LSB = 16;
   localparam int NUM_BLOCKS = 64;
   localparam int FIFO_DEPTH = 16;
   localparam int TABLE_BYTES = 24;
   localparam int VENDOR_ID_IDX = 16;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   // arbitrary neutral value
   localparam logic [7:0] VENDOR_ID_DEFAULT = 8'hA5;

   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_OUT,
      ST_DONE
   } flk_state_type;
endpackage

// *** rtl/flk_fifo.sv ***
// show-ahead fifo with flush for outgoing serial bytes
`timescale 1ns/1ps
module flk_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_flush,
   input wire logic i_push_valid,
   input wire logic [WIDTH-1:0] i_push_data,
   output logic o_push_ready,
   output logic o_pop_valid,
   output logic [WIDTH-1:0] o_pop_data,
   input wire logic i_pop_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } flk_fifo_type;

   flk_fifo_type r_q;
   flk_fifo_type r_d;
   logic do_push;
   logic do_pop;

   assign o_push_ready = (r_q.cnt != FULL_CNT);
   assign o_pop_valid = (r_q.cnt != '0);
   assign o_pop_data = r_q.mem[r_q.rp];
   assign do_push = i_push_valid & o_push_ready;
   assign do_pop = i_pop_ready & o_pop_valid;

   always_comb begin
      r_d = r_q;
      if (do_push) begin
         r_d.mem[r_q.wp] = i_push_data;
         r_d.wp = (r_q.wp == LAST_IDX) ? '0 : r_q.wp + 1'b1;
      end
      if (do_pop) begin
         r_d.rp = (r_q.rp == LAST_IDX) ? '0 : r_q.rp + 1'b1;
      end
      r_d.cnt = r_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (i_flush) begin
         r_d.wp = '0;
         r_d.rp = '0;
         r_d.cnt = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
endmodule // flk_fifo

// *** rtl/flk_cmd_decoder.sv ***
// command decoder for block lock, ready/busy, reset and discovery reads
// Summary of operation
// RULE1: block protection mode only when scheme bit set
// RULE2: lock status read only in block mode
// RULE3: opcode 3Ch, three address bytes, status returned
// RULE4: status bit one means protected, zero writable
// RULE5: gang commands lock or unlock all blocks
// RULE6: gang lock 7Eh, gang unlock 98h, single byte
// RULE7: gang commands need write enable latch set
// RULE8: chip select rising mid-byte rejects command
// RULE9: ready/busy enable drives status in continuous program
// RULE10: ready/busy disable stops that status output
// RULE11: no-operation only cancels a pending reset arm
// RULE12: reset executes only directly after reset arm
// RULE13: completed reset returns device to standby
// RULE14: reset aborts running program or erase
// RULE15: longer recovery after program than otherwise
// RULE16: table read 5Ah, address, dummy, stream out
// RULE17: table starts with fixed signature, low first
// RULE18: header revision, header count and fill bytes
// RULE19: first parameter header identifier and revision
// RULE20: first header length nine, pointer 30h
// RULE21: upper data lines ignored, serial in only
// RULE22: remaining opcodes taken from command set
`timescale 1ns/1ps
module flk_cmd_decoder #(
   parameter int NUM_BLOCKS = flk_pkg::NUM_BLOCKS,
   parameter int FIFO_DEPTH = flk_pkg::FIFO_DEPTH,
   parameter logic [7:0] VENDOR_ID = flk_pkg::VENDOR_ID_DEFAULT
) (
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   input wire logic I_SPI_CS_N,
   input wire logic I_SPI_SCLK,
   input wire logic I_SPI_SI,
   input wire logic I_PROT_SCHEME_SELECT,
   input wire logic I_WRITE_ENABLE_LATCH,
   input wire logic I_CONTINUOUS_PROGRAM_MODE,
   input wire logic I_BUSY,
   input wire logic I_PROGRAM_ACTIVE,
   output logic O_SPI_SO,
   output logic O_SPI_SO_OE,
   output logic O_GANG_LOCK_ALL,
   output logic O_GANG_UNLOCK_ALL,
   output logic O_WEL_CLEAR,
   output logic O_SW_RESET,
   output logic O_ABORT_OP,
   output logic O_RECOVERING,
   output logic O_RB_OUT_EN
);
   import flk_pkg::*;

   localparam int BLK_W = $clog2(NUM_BLOCKS);
   localparam logic [REC_W-1:0] REC_PROG = REC_W'(RECOV_PROG_CYC);
   localparam logic [REC_W-1:0] REC_OTHER = REC_W'(RECOV_OTHER_CYC);
   localparam logic [23:0] TABLE_END = 24'(TABLE_BYTES);
   localparam logic [23:0] VID_ADDR = 24'(VENDOR_ID_IDX);

   localparam logic [7:0] HDR_TABLE [TABLE_BYTES] = '{
      8'h53, 8'h46, 8'h44, 8'h50, // RULE17
      8'h00, 8'h01, 8'h01, 8'hFF, // RULE18
      8'h00, 8'h00, 8'h01, // RULE19
      8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, // RULE20
      8'hFF, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF
   };

   typedef struct packed {
      logic cs_s1, cs_s2, cs_s3;
      logic sck_s1, sck_s2, sck_s3;
      logic si_s1, si_s2;
      flk_state_type st;
      logic seen;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] shin, op;
      logic [23:0] addr, taddr;
      logic prod;
      logic [7:0] shout;
      logic dout, so, so_oe;
      logic lock_init;
      logic [NUM_BLOCKS-1:0] lock;
      logic rb_en;
      logic arm;
      logic [REC_W-1:0] rec;
      logic recovering;
      logic gang_lock, gang_unlock, wel_clr, sw_reset, abort;
   } flk_regs_type;

   flk_regs_type r_q;
   flk_regs_type r_d;
   logic push_valid, push_ready, pop_valid, pop_ready, flush;
   logic [7:0] push_data, pop_data;

   // block index from address bits A16 upward of the block field
   function automatic logic [BLK_W-1:0] blk_idx(input logic [23:0] a);
      return a[BLOCK_LSB +: BLK_W];
   endfunction

   // discovery byte, fill beyond the headers
   function automatic logic [7:0] table_byte(input logic [23:0] a);
      if (a == VID_ADDR) begin
         return VENDOR_ID;
      end
      return (a < TABLE_END) ? HDR_TABLE[a[4:0]] : FILL_BYTE;
   endfunction

   flk_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .i_clk(I_SYS_CLK), .i_srst(I_SRST), .i_flush(flush),
      .i_push_valid(push_valid), .i_push_data(push_data), .o_push_ready(push_ready),
      .o_pop_valid(pop_valid), .o_pop_data(pop_data), .i_pop_ready(pop_ready)
   );

   always_comb begin
      logic rise, fall, cs_low, cs_rise, ok;
      logic [7:0] sh;
      rise = 1'b0;
      fall = 1'b0;
      cs_low = 1'b0;
      cs_rise = 1'b0;
      ok = 1'b0;
      sh = 8'h00;
      r_d = r_q;
      // pin synchronisers
      r_d.cs_s1 = I_SPI_CS_N;
      r_d.cs_s2 = r_q.cs_s1;
      r_d.cs_s3 = r_q.cs_s2;
      r_d.sck_s1 = I_SPI_SCLK;
      r_d.sck_s2 = r_q.sck_s1;
      r_d.sck_s3 = r_q.sck_s2;
      r_d.si_s1 = I_SPI_SI;
      r_d.si_s2 = r_q.si_s1;
      rise = r_q.sck_s2 & ~r_q.sck_s3;
      fall = ~r_q.sck_s2 & r_q.sck_s3;
      cs_low = ~r_q.cs_s2;
      cs_rise = r_q.cs_s2 & ~r_q.cs_s3;
      sh = {r_q.shin[6:0], r_q.si_s2}; // RULE21
      r_d.gang_lock = 1'b0;
      r_d.gang_unlock = 1'b0;
      r_d.wel_clr = 1'b0;
      r_d.sw_reset = 1'b0;
      r_d.abort = 1'b0;
      push_valid = 1'b0;
      push_data = FILL_BYTE;
      pop_ready = 1'b0;
      flush = cs_rise;

      // power-up lock image follows the scheme bit
      if (!r_q.lock_init) begin
         r_d.lock_init = 1'b1;
         r_d.lock = {NUM_BLOCKS{I_PROT_SCHEME_SELECT}}; // RULE1
      end
      if (r_q.rec != '0) begin
         r_d.rec = r_q.rec - 1'b1;
      end

      // serial in on rising clock, ignored during recovery
      if (cs_low && rise && r_q.rec == '0 && r_q.st != ST_OUT) begin
         r_d.seen = 1'b1;
         r_d.shin = sh;
         r_d.bit_cnt = r_q.bit_cnt + 3'h1;
         if (r_q.bit_cnt == 3'h7) begin
            unique case (r_q.st)
               ST_OPCODE: begin
                  r_d.op = sh;
                  if ((sh == OP_READ_LOCK && I_PROT_SCHEME_SELECT) // RULE2 RULE3
                      || sh == OP_READ_TABLE) begin // RULE16
                     r_d.st = ST_ADDR;
                  end else begin
                     r_d.st = ST_DONE;
                  end
               end
               ST_ADDR: begin
                  r_d.addr = {r_q.addr[15:0], sh}; // RULE3
                  r_d.byte_cnt = r_q.byte_cnt + 2'h1;
                  if (r_q.byte_cnt == ADDR_LAST_BYTE) begin
                     r_d.prod = 1'b1;
                     r_d.taddr = {r_q.addr[15:0], sh};
                     r_d.st = (r_q.op == OP_READ_LOCK) ? ST_OUT : ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  r_d.st = ST_OUT; // RULE16
               end
               ST_DONE: begin
               end
               default: begin
                  r_d.st = ST_DONE;
               end
            endcase
         end
      end

      // producer keeps the fifo topped up
      if (r_q.prod && cs_low) begin
         push_valid = 1'b1;
         if (r_q.op == OP_READ_LOCK) begin
            push_data = {7'h00, r_q.lock[blk_idx(r_q.addr)]}; // RULE3 RULE4
         end else begin
            push_data = table_byte(r_q.taddr); // RULE16
            if (push_ready) begin
               r_d.taddr = r_q.taddr + 24'h1;
            end
         end
      end

      // serial out shifts on falling clock
      if (cs_low && fall && r_q.st == ST_OUT) begin
         r_d.bit_cnt = r_q.bit_cnt + 3'h1;
         if (r_q.bit_cnt == 3'h0) begin
            pop_ready = 1'b1;
            r_d.shout = pop_valid ? pop_data : FILL_BYTE;
         end
         r_d.dout = r_d.shout[7];
         r_d.shout = {r_d.shout[6:0], 1'b1};
      end

      // chip select rising ends every frame
      if (cs_rise) begin
         if (r_q.seen) begin
            ok = (r_q.st == ST_DONE) && (r_q.bit_cnt == 3'h0); // RULE8
            r_d.arm = 1'b0; // RULE11 RULE12
            if (ok) begin
               case (r_q.op)
                  OP_RESET_ARM: begin
                     r_d.arm = 1'b1;
                  end
                  OP_RESET: begin
                     if (r_q.arm) begin // RULE12
                        r_d.sw_reset = 1'b1;
                        r_d.rb_en = 1'b0; // RULE13
                        r_d.abort = I_BUSY; // RULE14
                        r_d.rec = I_PROGRAM_ACTIVE ? REC_PROG : REC_OTHER; // RULE15
                     end
                  end
                  OP_GANG_LOCK: begin // RULE6
                     if (I_PROT_SCHEME_SELECT && I_WRITE_ENABLE_LATCH) begin // RULE5 RULE7
                        r_d.lock = '1;
                        r_d.gang_lock = 1'b1;
                        r_d.wel_clr = 1'b1;
                     end
                  end
                  OP_GANG_UNLOCK: begin // RULE6
                     if (I_PROT_SCHEME_SELECT && I_WRITE_ENABLE_LATCH) begin // RULE5 RULE7
                        r_d.lock = '0;
                        r_d.gang_unlock = 1'b1;
                        r_d.wel_clr = 1'b1;
                     end
                  end
                  OP_RB_ENABLE: begin
                     r_d.rb_en = 1'b1; // RULE9 RULE22
                  end
                  OP_RB_DISABLE: begin
                     r_d.rb_en = 1'b0; // RULE10 RULE22
                  end
                  default: begin
                  end
               endcase
            end
         end
         r_d.st = ST_OPCODE;
         r_d.seen = 1'b0;
         r_d.bit_cnt = 3'h0;
         r_d.byte_cnt = 2'h0;
         r_d.prod = 1'b0;
         r_d.dout = 1'b1;
      end

      r_d.recovering = (r_d.rec != '0);
      // status on serial out while deselected in continuous program
      r_d.so_oe = (r_d.st == ST_OUT)
                  | (r_q.cs_s2 & r_d.rb_en & I_CONTINUOUS_PROGRAM_MODE); // RULE9 RULE10
      r_d.so = (r_d.st == ST_OUT) ? r_d.dout : ~I_BUSY; // RULE9
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         r_q <= '0;
         // select synchroniser starts at idle level, no false edge
         r_q.cs_s1 <= 1'b1;
         r_q.cs_s2 <= 1'b1;
         r_q.cs_s3 <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign O_SPI_SO = r_q.so;
   assign O_SPI_SO_OE = r_q.so_oe;
   assign O_GANG_LOCK_ALL = r_q.gang_lock;
   assign O_GANG_UNLOCK_ALL = r_q.gang_unlock;
   assign O_WEL_CLEAR = r_q.wel_clr;
   assign O_SW_RESET = r_q.sw_reset;
   assign O_ABORT_OP = r_q.abort;
   assign O_RECOVERING = r_q.recovering;
   assign O_RB_OUT_EN = r_q.rb_en;

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_SRST);
   a_lock_read_mode: assert property ( // RULE2
      $rose(r_q.st == ST_ADDR) && r_q.op == OP_READ_LOCK |-> $past(I_PROT_SCHEME_SELECT))
      else $error("lock status read accepted outside block mode");
   a_gang_unlock_all: assert property ( // RULE5
      r_q.gang_unlock |-> r_q.lock == '0 && r_q.wel_clr ##1 !r_q.gang_unlock)
      else $error("gang unlock left blocks locked");
   a_gang_needs_wel: assert property ( // RULE7
      r_q.gang_lock || r_q.gang_unlock
      |-> $past(I_WRITE_ENABLE_LATCH && I_PROT_SCHEME_SELECT))
      else $error("gang command ran without write enable");
   a_byte_boundary: assert property ( // RULE8
      $changed(r_q.rb_en) && !r_q.sw_reset
      |-> $past(r_q.st == ST_DONE && r_q.bit_cnt == 3'h0 && r_q.seen))
      else $error("command executed off a byte boundary");
   a_rb_shows_busy: assert property ( // RULE9
      r_q.so_oe && r_q.st != ST_OUT |-> r_q.so == !$past(I_BUSY))
      else $error("ready/busy level wrong on serial out");
   a_rb_gated_off: assert property ( // RULE10
      r_q.so_oe && r_q.st != ST_OUT
      |-> r_q.rb_en && $past(I_CONTINUOUS_PROGRAM_MODE) && $past(r_q.cs_s2))
      else $error("ready/busy driven while disabled");
   a_reset_armed: assert property ( // RULE12
      r_q.sw_reset |-> $past(r_q.arm) && !r_q.arm)
      else $error("reset ran without a directly preceding arm");
   a_reset_standby: assert property ( // RULE13
      r_q.sw_reset |-> r_q.st == ST_OPCODE && !r_q.rb_en ##1 !r_q.sw_reset)
      else $error("reset did not return to standby");
   a_reset_abort: assert property ( // RULE14
      r_q.sw_reset |-> r_q.abort == $past(I_BUSY))
      else $error("abort does not follow busy at reset");
   a_recovery_len: assert property ( // RULE15
      r_q.sw_reset
      |-> r_q.rec == ($past(I_PROGRAM_ACTIVE) ? REC_PROG : REC_OTHER) ##1 O_RECOVERING [*8])
      else $error("recovery time wrong after reset");
   a_signature_byte: assert property ( // RULE17
      push_valid && r_q.op == OP_READ_TABLE && r_q.taddr == 24'h0 |-> push_data == 8'h53)
      else $error("discovery signature does not start with low byte");
endmodule // flk_cmd_decoder

// *** tb/flk_host_model.sv ***
// host serial controller model that frames commands into the decoder
`timescale 1ns/1ps
module flk_host_model (
   input wire logic i_clk,
   input wire logic i_recovering,
   input wire logic i_so,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_si
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
   end

   // n_tx bits left aligned in tx go out msb first, then n_rx bits come back
   task automatic xfer(input logic [39:0] tx, input int n_tx, input int n_rx,
                       output logic [63:0] rx);
      int w;
      rx = '0;
      w = 0;
      while (i_recovering && w < 2000) begin
         @(negedge i_clk);
         w++;
      end
      @(negedge i_clk);
      o_cs_n = 1'b0;
      for (int b = 0; b < n_tx + n_rx; b++) begin
         if (b < n_tx) begin
            o_si = tx[39-b];
         end else begin
            o_si = ~o_si;
         end
         repeat (4) @(negedge i_clk);
         o_sclk = 1'b1;
         repeat (4) @(negedge i_clk);
         if (b >= n_tx) begin
            rx = {rx[62:0], i_so};
         end
         o_sclk = 1'b0;
      end
      repeat (4) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (8) @(negedge i_clk);
   endtask
endmodule // flk_host_model

// *** tb/flk_cmd_decoder_tb.sv ***
// self-checking bench for the lock, reset and discovery-table decoder
`timescale 1ns/1ps
module flk_cmd_decoder_tb;
   import flk_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic prot = 1'b1, wel = 1'b0, cp = 1'b0, busy = 1'b0, prog = 1'b0;
   logic cs_n, sclk, si, so, so_oe, glock, gunlock, wclr, swrst, abort, recov, rb_en;
   logic [63:0] rx;
   int errors = 0, comparisons = 0, cyc = 0;
   int n_lock = 0, n_unl = 0, n_wclr = 0, n_rst = 0, n_abort = 0, n_oe = 0, rec_n = 0;
   localparam logic [7:0] TBL [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
      8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, VENDOR_ID_DEFAULT,
      8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};

   always #25 clk = ~clk;

   flk_host_model i_flk_host_model (.i_clk(clk), .i_recovering(recov), .i_so(so),
      .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

   flk_cmd_decoder i_flk_cmd_decoder (.I_SYS_CLK(clk), .I_SRST(srst), .I_SPI_CS_N(cs_n),
      .I_SPI_SCLK(sclk), .I_SPI_SI(si), .I_PROT_SCHEME_SELECT(prot),
      .I_WRITE_ENABLE_LATCH(wel), .I_CONTINUOUS_PROGRAM_MODE(cp), .I_BUSY(busy),
      .I_PROGRAM_ACTIVE(prog), .O_SPI_SO(so), .O_SPI_SO_OE(so_oe),
      .O_GANG_LOCK_ALL(glock), .O_GANG_UNLOCK_ALL(gunlock), .O_WEL_CLEAR(wclr),
      .O_SW_RESET(swrst), .O_ABORT_OP(abort), .O_RECOVERING(recov), .O_RB_OUT_EN(rb_en));

   // pulse and level monitors, sampled where outputs are settled
   always @(negedge clk) begin
      n_lock += int'(glock === 1'b1);
      n_unl += int'(gunlock === 1'b1);
      n_wclr += int'(wclr === 1'b1);
      n_rst += int'(swrst === 1'b1);
      n_abort += int'(abort === 1'b1);
      n_oe += int'(so_oe === 1'b1);
      rec_n += int'(recov === 1'b1);
      cyc++;
      if (cyc == 60000) begin
         errors++;
         $display("unexpected at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input int nbits);
      i_flk_host_model.xfer({op, 32'h0}, nbits, 0, rx);
   endtask

   task automatic lock_rd(input logic [23:0] a, input logic l);
      i_flk_host_model.xfer({OP_READ_LOCK, a, 8'h00}, 32, 16, rx);
      chk(rx, {48'h0, 7'h0, l, 7'h0, l});
   endtask

   task automatic tbl_rd(input logic [7:0] a, input int nb);
      logic [63:0] e;
      e = '0;
      for (int i = 0; i < nb; i++) begin
         e = {e[55:0], (int'(a) + i < TABLE_BYTES) ? TBL[int'(a) + i] : FILL_BYTE};
      end
      i_flk_host_model.xfer({OP_READ_TABLE, 16'h0, a, 8'h00}, 40, 8 * nb, rx);
      chk(rx, e);
   endtask

   task automatic rec_wait();
      for (int w = 0; w < 1000 && recov === 1'b1; w++) begin
         @(negedge clk);
      end
   endtask

   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      chk({so_oe, rb_en, recov}, 3'h0);
      lock_rd(24'h010000, 1'b1);
      wel = 1'b1;
      cmd(OP_GANG_UNLOCK, 8);
      chk({n_unl, n_wclr}, {32'd1, 32'd1});
      lock_rd(24'h3F5000, 1'b0);
      wel = 1'b0;
      cmd(OP_GANG_LOCK, 8);
      chk(n_lock, 0);
      wel = 1'b1;
      cmd(OP_GANG_LOCK, 9);
      cmd(OP_GANG_LOCK, 7);
      chk(n_lock, 0);
      cmd(OP_GANG_LOCK, 8);
      chk(n_lock, 1);
      lock_rd(24'h200000, 1'b1);
      prot = 1'b0;
      n_oe = 0;
      cmd(OP_GANG_UNLOCK, 8);
      chk(n_unl, 1);
      i_flk_host_model.xfer({OP_READ_LOCK, 32'h0}, 32, 16, rx);
      chk(n_oe, 0);
      prot = 1'b1;
      $display("end of test lock");
      cmd(OP_RB_ENABLE, 8);
      chk(rb_en, 1'b1);
      cp = 1'b1;
      busy = 1'b1;
      repeat (3) @(negedge clk);
      chk({so_oe, so}, 2'b10);
      busy = 1'b0;
      repeat (3) @(negedge clk);
      chk({so_oe, so}, 2'b11);
      cmd(OP_RB_DISABLE, 7);
      chk(rb_en, 1'b1);
      cmd(OP_RB_DISABLE, 8);
      repeat (3) @(negedge clk);
      chk({rb_en, so_oe}, 2'b00);
      cp = 1'b0;
      $display("end of test ready busy");
      cmd(OP_RB_ENABLE, 8);
      cmd(OP_RESET_ARM, 8);
      cmd(OP_NOP, 8);
      cmd(OP_RESET, 8);
      chk({n_rst, 31'h0, rb_en}, 64'h1);
      cmd(OP_RESET_ARM, 8);
      cmd(OP_RB_ENABLE, 8);
      cmd(OP_RESET, 8);
      chk(n_rst, 0);
      busy = 1'b1;
      prog = 1'b1;
      rec_n = 0;
      cmd(OP_RESET_ARM, 8);
      cmd(OP_RESET, 8);
      chk({n_rst, n_abort}, {32'd1, 32'd1});
      chk(rb_en, 1'b0);
      rec_wait();
      chk(rec_n, RECOV_PROG_CYC);
      busy = 1'b0;
      prog = 1'b0;
      rec_n = 0;
      cmd(OP_RESET_ARM, 8);
      cmd(OP_RESET, 8);
      rec_wait();
      chk({n_rst, n_abort}, {32'd2, 32'd1});
      chk(rec_n, RECOV_OTHER_CYC);
      $display("end of test reset");
      tbl_rd(8'h00, 8);
      tbl_rd(8'h08, 8);
      tbl_rd(8'h10, 1);
      tbl_rd(8'h18, 2);
      $display("end of test table");
      tbl_rd(8'h00, 24);
      tbl_rd(8'h04, 22);
      lock_rd(24'h0A3000, 1'b1);
      chk(so_oe, 1'b0);
      $display("end of test stream");
      close_out();
   end
endmodule // flk_cmd_decoder_tb
